// ### verilog/brg_pkg.sv
/*
 * Package for the board reset and SRAM glue block: timing constants,
 * reset state codes, bank decode constants and the carrier structs.
 * Assumes a single 25 MHz core clock.
 */
package brg_pkg;

    // Clock period in ns
    localparam int CLK_PERIOD_NS = 40;

    // Button debounce time in us and the derived cycle count
    localparam int DEBOUNCE_US = 1000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;

    // Power-on reset hold in us and the derived cycle count
    localparam int POR_HOLD_US = 2000;
    localparam int POR_CYCLES = (POR_HOLD_US * 1000) / CLK_PERIOD_NS;

    // Core reset stretch in cycles, gives the debugger a window
    localparam int CORE_STRETCH_CYCLES = 16;

    localparam int CNT_W = 24;

    // Bank 0 boot defaults: flash at address zero, 16-bit, max waits
    localparam logic [1:0] BUS_WIDTH_16 = 2'h2;
    localparam logic [3:0] MAX_WAIT_STATES = 4'h7;
    localparam logic [25:0] BANK0_BASE = 26'h000_0000;

    // Flash and SRAM geometry
    localparam int FLASH_BYTES = 524288;
    localparam int FLASH_DATA_W = 16;
    localparam int SRAM_WORDS = 65536;
    localparam int SRAM_DEV_W = 16;
    localparam int NUM_SRAM_BANKS = 2;

    // Reset sequencer states
    typedef enum logic [3:0] {
        BRG_POR = 4'h1,
        BRG_RUN = 4'h2,
        BRG_SYS_RST = 4'h4,
        BRG_CORE_RST = 4'h8
    } brg_state_t;

    // Memory strobes from the microcontroller, all active low
    typedef struct packed {
        logic [2:0] chip_select_n;
        logic output_enable_n;
        logic [3:0] write_byte_enable_n;
    } brg_mem_strobe_t;

    // Strobes to one 16-bit SRAM device
    typedef struct packed {
        logic chip_enable_n;
        logic upper_byte_select;
        logic lower_byte_select;
        logic write_enable_n;
    } brg_sram_dev_t;

    // Boot configuration of bank 0
    typedef struct packed {
        logic [25:0] base;
        logic [1:0] bus_width_config;
        logic [3:0] wait_states;
    } brg_boot_cfg_t;

endpackage : brg_pkg

// ### verilog/brg_glue.sv
/*
 * Board reset and SRAM glue: debounced reset buttons, power-on hold,
 * core and test-logic reset outputs, SRAM byte select and write enable.
 * Assumes button inputs are asynchronous and active high when pressed,
 * and memory strobes come from logic on core_clk.
 */
// Summary of operation
// - System reset button asserts core reset and test-logic reset together.
// - Core reset button asserts only core reset; test-logic reset stays high.
// - Test-logic reset drives only the test-access and debug logic.
// - System button is debounced; reset held for a power-on delay.
// - Core-only reset lets a debugger halt the core before first fetch.
// - Out of reset bank 0 maps at zero, 16-bit, maximum wait states.
// - Flash is one 512KB 16-bit device on bank 0 chip select.
// - In each array one device takes low half, one the upper half.
// - Byte selects are AND of output enable and that lane's write enable.
// - Device write enable is AND of its two lanes' write enables.
// - External address shift follows the programmed bus width value.
`timescale 1ns/10ps
module brg_glue (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic system_reset_button,
    input wire logic core_reset_button,
    input wire brg_pkg::brg_mem_strobe_t mem_strobe,
    input wire logic [1:0] bus_width_config,
    input wire logic [17:0] cpu_addr,
    output logic core_reset_n,
    output logic test_logic_reset_n,
    output logic flash_chip_select_n,
    output brg_pkg::brg_sram_dev_t [3:0] sram_dev,
    output logic [15:0] ext_addr,
    output brg_pkg::brg_boot_cfg_t boot_cfg
);

    logic [2:0] sys_sync_ff;
    logic [2:0] core_sync_ff;
    logic sys_level_ff;
    logic core_level_ff;
    logic [brg_pkg::CNT_W-1:0] sys_db_cnt_ff;
    logic [brg_pkg::CNT_W-1:0] core_db_cnt_ff;
    logic [brg_pkg::CNT_W-1:0] hold_cnt_ff;
    brg_pkg::brg_state_t state_ff;
    logic core_reset_n_ff;
    logic test_logic_reset_n_ff;
    logic nxt_sys_level;
    logic nxt_core_level;
    logic [brg_pkg::CNT_W-1:0] nxt_sys_db_cnt;
    logic [brg_pkg::CNT_W-1:0] nxt_core_db_cnt;
    logic [brg_pkg::CNT_W-1:0] nxt_hold_cnt;
    brg_pkg::brg_state_t nxt_state;
    logic nxt_core_reset_n;
    logic nxt_test_logic_reset_n;

    // Debounce: a new level counts only after it stays stable long enough
    always_comb begin
        nxt_sys_level = sys_level_ff;
        nxt_core_level = core_level_ff;
        nxt_sys_db_cnt = '0;
        nxt_core_db_cnt = '0;
        if (sys_sync_ff[2] == sys_sync_ff[1] && sys_sync_ff[2] != sys_level_ff) begin
            nxt_sys_db_cnt = sys_db_cnt_ff + 1'b1;
            if (sys_db_cnt_ff == brg_pkg::CNT_W'(brg_pkg::DEBOUNCE_CYCLES - 1)) begin
                nxt_sys_level = sys_sync_ff[2];
                nxt_sys_db_cnt = '0;
            end
        end
        // Core button gets the same filter so contact bounce cannot retrigger
        if (core_sync_ff[2] == core_sync_ff[1] && core_sync_ff[2] != core_level_ff) begin
            nxt_core_db_cnt = core_db_cnt_ff + 1'b1;
            if (core_db_cnt_ff == brg_pkg::CNT_W'(brg_pkg::DEBOUNCE_CYCLES - 1)) begin
                nxt_core_level = core_sync_ff[2];
                nxt_core_db_cnt = '0;
            end
        end
    end

    // Three-stage synchronisers and debounce registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sys_sync_ff <= 3'h0;
            core_sync_ff <= 3'h0;
            sys_level_ff <= 1'b0;
            core_level_ff <= 1'b0;
            sys_db_cnt_ff <= '0;
            core_db_cnt_ff <= '0;
        end else begin
            sys_sync_ff <= {sys_sync_ff[1:0], system_reset_button};
            core_sync_ff <= {core_sync_ff[1:0], core_reset_button};
            sys_level_ff <= nxt_sys_level;
            core_level_ff <= nxt_core_level;
            sys_db_cnt_ff <= nxt_sys_db_cnt;
            core_db_cnt_ff <= nxt_core_db_cnt;
        end
    end

    // Reset sequencer; system button wins over core button
    always_comb begin
        nxt_state = state_ff;
        nxt_hold_cnt = hold_cnt_ff;
        nxt_core_reset_n = 1'b1;
        nxt_test_logic_reset_n = 1'b1;
        unique case (state_ff)
            brg_pkg::BRG_POR: begin
                // Power-on hold keeps both resets asserted
                nxt_core_reset_n = 1'b0;
                nxt_test_logic_reset_n = 1'b0;
                nxt_hold_cnt = hold_cnt_ff + 1'b1;
                if (hold_cnt_ff >= brg_pkg::CNT_W'(brg_pkg::POR_CYCLES - 1)) begin
                    nxt_state = brg_pkg::BRG_RUN;
                    nxt_hold_cnt = '0;
                    nxt_core_reset_n = 1'b1;
                    nxt_test_logic_reset_n = 1'b1;
                end
            end
            brg_pkg::BRG_RUN: begin
                nxt_hold_cnt = '0;
                if (sys_level_ff) begin
                    nxt_state = brg_pkg::BRG_SYS_RST;
                    nxt_core_reset_n = 1'b0;
                    nxt_test_logic_reset_n = 1'b0;
                end else if (core_level_ff) begin
                    nxt_state = brg_pkg::BRG_CORE_RST;
                    nxt_core_reset_n = 1'b0;
                end
            end
            brg_pkg::BRG_SYS_RST: begin
                nxt_core_reset_n = 1'b0;
                nxt_test_logic_reset_n = 1'b0;
                // Release after the button lifts, then a fresh power-on style hold
                if (!sys_level_ff) begin
                    nxt_state = brg_pkg::BRG_POR;
                    nxt_hold_cnt = '0;
                end
            end
            brg_pkg::BRG_CORE_RST: begin
                // Test logic untouched so an attached debugger keeps control
                nxt_core_reset_n = 1'b0;
                if (sys_level_ff) begin
                    nxt_state = brg_pkg::BRG_SYS_RST;
                    nxt_test_logic_reset_n = 1'b0;
                    nxt_hold_cnt = '0;
                end else if (!core_level_ff) begin
                    nxt_hold_cnt = hold_cnt_ff + 1'b1;
                    // Short stretch after release gives a clean core reset edge
                    if (hold_cnt_ff >= brg_pkg::CNT_W'(brg_pkg::CORE_STRETCH_CYCLES - 1)) begin
                        nxt_state = brg_pkg::BRG_RUN;
                        nxt_hold_cnt = '0;
                        nxt_core_reset_n = 1'b1;
                    end
                end else begin
                    nxt_hold_cnt = '0;
                end
            end
            default: begin
                nxt_state = brg_pkg::BRG_POR;
                nxt_hold_cnt = '0;
                nxt_core_reset_n = 1'b0;
                nxt_test_logic_reset_n = 1'b0;
            end
        endcase
    end

    // Reset sequencer registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff <= brg_pkg::BRG_POR;
            hold_cnt_ff <= '0;
            core_reset_n_ff <= 1'b0;
            test_logic_reset_n_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hold_cnt_ff <= nxt_hold_cnt;
            core_reset_n_ff <= nxt_core_reset_n;
            test_logic_reset_n_ff <= nxt_test_logic_reset_n;
        end
    end

    assign core_reset_n = core_reset_n_ff;
    assign test_logic_reset_n = test_logic_reset_n_ff;

    // SRAM strobe next values; index 0,1 bank 1 low/high, 2,3 bank 2
    brg_pkg::brg_sram_dev_t [3:0] nxt_sram_dev;
    brg_pkg::brg_sram_dev_t [3:0] sram_dev_ff;
    logic nxt_flash_cs_n;
    logic flash_cs_n_ff;
    logic [15:0] nxt_ext_addr;
    logic [15:0] ext_addr_ff;

    // Byte lane gating, one device per half word
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dev
            localparam int BANK = gi / 2 + 1;
            localparam int LANE = (gi % 2) * 2;
            always_comb begin
                nxt_sram_dev[gi].chip_enable_n = mem_strobe.chip_select_n[BANK];
                nxt_sram_dev[gi].lower_byte_select = mem_strobe.output_enable_n
                    & mem_strobe.write_byte_enable_n[LANE];
                nxt_sram_dev[gi].upper_byte_select = mem_strobe.output_enable_n
                    & mem_strobe.write_byte_enable_n[LANE + 1];
                nxt_sram_dev[gi].write_enable_n = mem_strobe.write_byte_enable_n[LANE]
                    & mem_strobe.write_byte_enable_n[LANE + 1];
            end
        end
    endgenerate

    // Flash select and address shift by bus width
    always_comb begin
        nxt_flash_cs_n = mem_strobe.chip_select_n[0];
        unique case (bus_width_config)
            2'h1: nxt_ext_addr = cpu_addr[15:0];
            brg_pkg::BUS_WIDTH_16: nxt_ext_addr = cpu_addr[16:1];
            2'h3: nxt_ext_addr = cpu_addr[17:2];
            default: nxt_ext_addr = cpu_addr[16:1];
        endcase
    end

    // Output registers; strobes lag the microcontroller by one cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sram_dev_ff <= {4{4'hF}};
            flash_cs_n_ff <= 1'b1;
            ext_addr_ff <= 16'h0000;
        end else begin
            sram_dev_ff <= nxt_sram_dev;
            flash_cs_n_ff <= nxt_flash_cs_n;
            ext_addr_ff <= nxt_ext_addr;
        end
    end

    assign sram_dev = sram_dev_ff;
    assign flash_chip_select_n = flash_cs_n_ff;
    assign ext_addr = ext_addr_ff;

    // Boot configuration for bank 0 is a constant register value
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            boot_cfg <= '0;
        end else begin
            boot_cfg <= {brg_pkg::BANK0_BASE, brg_pkg::BUS_WIDTH_16,
                         brg_pkg::MAX_WAIT_STATES};
        end
    end

endmodule : brg_glue

// ### dv/brg_glue_monitor.sv
/*
 * Checker for the board reset and SRAM glue: reset outputs and strobe gating.
 * Assumes it is bound to brg_glue and sees only that module's ports.
 */
`timescale 1ns/10ps
module brg_glue_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire brg_pkg::brg_mem_strobe_t mem_strobe,
    input wire logic [1:0] bus_width_config,
    input wire logic [17:0] cpu_addr,
    input wire logic core_reset_n,
    input wire logic test_logic_reset_n,
    input wire logic flash_chip_select_n,
    input wire brg_pkg::brg_sram_dev_t [3:0] sram_dev,
    input wire logic [15:0] ext_addr,
    input wire brg_pkg::brg_boot_cfg_t boot_cfg
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // Strobes lag one edge, so the edge leaving reset still shows reset values
    sequence settled;
        !$past(reset);
    endsequence
    sequence por_start;
        $fell(reset);
    endsequence

    test_with_core_a: assert property (!test_logic_reset_n |-> !core_reset_n)
        else $error("test logic reset low while core runs");
    por_hold_a: assert property (por_start |->
        (!core_reset_n && !test_logic_reset_n) [*8]) else $error("power-on hold too short");
    flash_select_a: assert property (settled |->
        flash_chip_select_n == $past(mem_strobe.chip_select_n[0])) else $error("flash select");
    bank_decode_a: assert property (settled |->
        sram_dev[1].chip_enable_n == $past(mem_strobe.chip_select_n[1]) &&
        sram_dev[2].chip_enable_n == $past(mem_strobe.chip_select_n[2]))
        else $error("sram chip enable");
    byte_select_a: assert property (settled |->
        sram_dev[1].upper_byte_select ==
        $past(mem_strobe.output_enable_n & mem_strobe.write_byte_enable_n[3]) &&
        sram_dev[2].lower_byte_select ==
        $past(mem_strobe.output_enable_n & mem_strobe.write_byte_enable_n[0]))
        else $error("byte select");
    dev_write_a: assert property (settled |->
        sram_dev[0].write_enable_n == $past(&mem_strobe.write_byte_enable_n[1:0]) &&
        sram_dev[3].write_enable_n == $past(&mem_strobe.write_byte_enable_n[3:2]))
        else $error("sram write enable");
    addr_shift_a: assert property (settled |-> $past(bus_width_config) != 2'h3 ||
        ext_addr == $past(cpu_addr[17:2])) else $error("word address shift");
    boot_map_a: assert property (core_reset_n |->
        boot_cfg == {26'h000_0000, 2'h2, 4'h7}) else $error("boot configuration");
endmodule : brg_glue_monitor

bind brg_glue brg_glue_monitor u_mon (.core_clk, .reset, .mem_strobe, .bus_width_config,
    .cpu_addr, .core_reset_n, .test_logic_reset_n, .flash_chip_select_n, .sram_dev,
    .ext_addr, .boot_cfg);

// ### dv/brg_sram_model.sv
/*
 * Model of the two SRAM arrays: reports which byte lanes a strobe set reaches.
 * Assumes device order bank 1 low, bank 1 high, bank 2 low, bank 2 high.
 */
`timescale 1ns/10ps
module brg_sram_model (
    input wire brg_pkg::brg_sram_dev_t [3:0] sram_dev,
    output logic [7:0] lane_access,
    output logic [7:0] lane_write
);
    // Lane 2d is the low byte of device d; a write needs the lane's access and the device write enable
    always_comb begin
        for (int d = 0; d < 4; d++) begin
            lane_access[2*d] = !sram_dev[d].chip_enable_n && !sram_dev[d].lower_byte_select;
            lane_access[2*d+1] = !sram_dev[d].chip_enable_n && !sram_dev[d].upper_byte_select;
            lane_write[2*d] = lane_access[2*d] && !sram_dev[d].write_enable_n;
            lane_write[2*d+1] = lane_access[2*d+1] && !sram_dev[d].write_enable_n;
        end
    end
endmodule : brg_sram_model

// ### dv/test_board_reset_and_sram_glue.sv
/*
 * Self-checking bench for the glue: power-on hold, strobe gating, buttons.
 * Assumes the package's full debounce and power-on counts.
 */
`timescale 1ns/10ps
module test_board_reset_and_sram_glue;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic system_reset_button = 1'b0;
    logic core_reset_button = 1'b0;
    brg_pkg::brg_mem_strobe_t mem_strobe = 8'hff;
    logic [1:0] bus_width_config = 2'h2;
    logic [17:0] cpu_addr = 18'h0_0000;
    logic core_reset_n, test_logic_reset_n, flash_chip_select_n;
    brg_pkg::brg_sram_dev_t [3:0] sram_dev;
    logic [15:0] ext_addr;
    brg_pkg::brg_boot_cfg_t boot_cfg;
    logic [7:0] lane_access, lane_write;
    int num_errors = 0;
    int n_checks = 0;
    // Bank 1 read, bank 2 byte write, bank 1 half write, flash read, bank 2 word write, idle
    localparam logic [7:0] strobe_pat [6] = '{8'haf, 8'h7b, 8'hb3, 8'hcf, 8'h70, 8'hff};

    // 25 MHz clock
    initial begin
        forever #20 core_clk = ~core_clk;
    end

    brg_glue dut (.core_clk, .reset, .system_reset_button, .core_reset_button, .mem_strobe,
        .bus_width_config, .cpu_addr, .core_reset_n, .test_logic_reset_n,
        .flash_chip_select_n, .sram_dev, .ext_addr, .boot_cfg);
    brg_sram_model u_sram (.sram_dev, .lane_access, .lane_write);

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // Bounded wait for a reset output; running out ends the run
    task automatic wait_for(input bit test_out, input logic level, input int bound);
        for (int i = 0; i < bound; i++) begin
            if ((test_out ? test_logic_reset_n : core_reset_n) === level) return;
            @(posedge core_clk);
            #1;
        end
        num_errors++;
        $display("unexpected reset level: expected %b, seen timeout", level);
        end_sim();
    endtask : wait_for

    // While reset is held both resets are asserted, strobes idle and the boot word is cleared
    task automatic t_in_reset();
        check("core_reset_n", 1'b0, core_reset_n);
        check("test_logic_reset_n", 1'b0, test_logic_reset_n);
        check("flash_chip_select_n", 1'b1, flash_chip_select_n);
        check("sram_dev", 16'hffff, sram_dev);
        check("boot_cfg", 32'h0000_0000, boot_cfg);
    endtask : t_in_reset

    task automatic t_power_on();
        repeat (brg_pkg::POR_CYCLES - 8) @(posedge core_clk);
        #1;
        check("core_reset_n", 1'b0, core_reset_n);
        check("test_logic_reset_n", 1'b0, test_logic_reset_n);
        wait_for(1'b0, 1'b1, 40);
        check("test_logic_reset_n", 1'b1, test_logic_reset_n);
        check("boot_cfg", {26'h000_0000, 2'h2, 4'h7}, boot_cfg);
    endtask : t_power_on

    task automatic t_strobes();
        brg_pkg::brg_mem_strobe_t m;
        brg_pkg::brg_sram_dev_t [3:0] dev;
        logic lb, ub;
        logic [7:0] acc, wr;
        logic [15:0] ea;
        for (int i = 0; i < 6; i++) begin
            mem_strobe = strobe_pat[i];
            bus_width_config = 2'(i);
            cpu_addr = 18'h2_d5a7 + 18'(i * 4097);
            @(posedge core_clk);
            #1;
            m = mem_strobe;
            for (int d = 0; d < 4; d++) begin
                lb = m.write_byte_enable_n[2*(d%2)];
                ub = m.write_byte_enable_n[2*(d%2)+1];
                dev[d] = {m.chip_select_n[1+d/2], m.output_enable_n & ub,
                    m.output_enable_n & lb, lb & ub};
                acc[2*d] = !m.chip_select_n[1+d/2] && !(m.output_enable_n & lb);
                acc[2*d+1] = !m.chip_select_n[1+d/2] && !(m.output_enable_n & ub);
                wr[2*d+:2] = acc[2*d+:2] & {2{!(lb & ub)}};
            end
            case (bus_width_config)
                2'h1: ea = cpu_addr[15:0];
                2'h3: ea = cpu_addr[17:2];
                default: ea = cpu_addr[16:1];
            endcase
            check("sram_dev", dev, sram_dev);
            check("lane_access", acc, lane_access);
            check("lane_write", wr, lane_write);
            check("flash_chip_select_n", m.chip_select_n[0], flash_chip_select_n);
            check("ext_addr", ea, ext_addr);
        end
    endtask : t_strobes

    // Short bounce first, then core press, then the system press escalates
    task automatic t_buttons();
        // A press shorter than the debounce time must reach neither reset
        system_reset_button = 1'b1;
        repeat (100) @(posedge core_clk);
        #1;
        system_reset_button = 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        check("test_logic_reset_n", 1'b1, test_logic_reset_n);
        check("core_reset_n", 1'b1, core_reset_n);
        core_reset_button = 1'b1;
        repeat (200) @(posedge core_clk);
        #1;
        check("core_reset_n", 1'b1, core_reset_n);
        system_reset_button = 1'b1;
        wait_for(1'b0, 1'b0, brg_pkg::DEBOUNCE_CYCLES + 20);
        check("test_logic_reset_n", 1'b1, test_logic_reset_n);
        wait_for(1'b1, 1'b0, 400);
        check("core_reset_n", 1'b0, core_reset_n);
    endtask : t_buttons

    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        t_in_reset();
        reset = 1'b0;
        t_power_on();
        t_strobes();
        t_buttons();
        end_sim();
    end
endmodule : test_board_reset_and_sram_glue
